/* File: hw/pfs_params.svh */
// constants for the power fault supervisor: bit positions, times, widths
// assumes a 50 MHz core clock; cycle counts are derived where used
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH

`define PFS_CLK_MHZ        50
`define PFS_NUM_RAILS      8
`define PFS_NUM_SYNC       13
// synchroniser reset: supply fault assumed until its pin is seen clear
`define PFS_SYNC_RESET     13'h0200

// times in their own units
`define PFS_T_FILT_NS      25000
`define PFS_T_HOLD_NS      250000
`define PFS_T_PGTMO_US     14000
`define PFS_T_INHIBIT_MS   1000

// counter widths
`define PFS_FILT_CW        16
`define PFS_TMO_CW         20
`define PFS_INH_CW         26

// power_good_status bit per rail
`define PFS_PGS_ALWAYS_ON  0
`define PFS_PGS_BUCK1      1
`define PFS_PGS_BUCK2      2
`define PFS_PGS_BUCK3      3
`define PFS_PGS_BUCKBOOST  4
`define PFS_PGS_LIN2       5
`define PFS_PGS_LIN3       6
`define PFS_PGS_LIN4       7
`define PFS_PGS_RESET      8'h00

// fault_event_status bits
`define PFS_FES_PG_TMO     3
`define PFS_FES_UV_WARN    4
`define PFS_FES_UV_FAULT   5
`define PFS_FES_OT_WARN    6
`define PFS_FES_OT_FAULT   7
`define PFS_FES_LO         3
`define PFS_FES_RESET      8'h00

`endif

/* File: hw/pfs_pkg.sv */
// types shared by the power fault supervisor modules
// widths come from pfs_params.svh
`include "pfs_params.svh"

package pfs_pkg;

  typedef enum logic [1:0] {
    PFS_SEQ_RUN  = 2'b00,
    PFS_SEQ_DOWN = 2'b01,
    PFS_SEQ_OFF  = 2'b10
  } pfs_seq_e;

  // monitor and request pins, all asynchronous
  typedef struct packed {
    logic power_on_request;
    logic ot_fault;
    logic ot_warn;
    logic uv_fault;
    logic uv_warn;
  } pfs_mon_s;

  typedef struct packed {
    logic                     good;
    logic [`PFS_FILT_CW-1:0]  cnt;
  } pfs_filt_s;

  typedef struct packed {
    pfs_seq_e                 seq;
    logic [`PFS_INH_CW-1:0]   inh_cnt;
    logic [`PFS_TMO_CW-1:0]   tmo_cnt;
    logic                     tmo;
    logic                     uv_armed;
    logic [7:`PFS_FES_LO]     status;
    logic [7:`PFS_FES_LO]     clr_seen;
    logic [7:`PFS_FES_LO]     cond_prev;
    logic                     fault_alert;
    logic                     pg;
    logic                     wake;
    logic                     hard_reset;
    logic                     output_enable_register_clear;
  } pfs_top_s;

endpackage

/* File: hw/pfs_sync.sv */
// three-stage synchroniser for asynchronous pins
// output follows once stages two and three agree
`timescale 1ns/1ns

module pfs_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pfs_sync_s;

  pfs_sync_s st_q;
  pfs_sync_s st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.q[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.q;
endmodule

/* File: hw/pfs_rail_filter.sv */
// power-good qualifier for one rail
// in_window is already synchronised; rail_on comes from core_clk logic
`timescale 1ns/1ns
`include "pfs_params.svh"

module pfs_rail_filter #(
  parameter int FILT_CYC = 1,
  parameter int HOLD_CYC = 1
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic rail_on,
  input  wire logic in_window,
  output logic      good
);
  import pfs_pkg::*;

  pfs_filt_s st_q;
  pfs_filt_s st_d;

  always_comb begin
    st_d = st_q;
    if (!rail_on) begin
      st_d.good = 1'b0;
      st_d.cnt  = '0;
    end else if (st_q.good == in_window) begin
      // glitch shorter than the filter restarts the count
      st_d.cnt = '0;
    end else if (st_q.good) begin
      if (st_q.cnt == `PFS_FILT_CW'(FILT_CYC - 1)) begin
        st_d.good = 1'b0;
        st_d.cnt  = '0;
      end else begin
        st_d.cnt = st_q.cnt + `PFS_FILT_CW'(1);
      end
    end else begin
      if (st_q.cnt == `PFS_FILT_CW'(HOLD_CYC - 1)) begin
        st_d.good = 1'b1;
        st_d.cnt  = '0;
      end else begin
        st_d.cnt = st_q.cnt + `PFS_FILT_CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign good = st_q.good;
endmodule

/* File: hw/pfs_supervisor.sv */
// power fault supervisor: power-good qualification, fault status, alert,
// and the fault-induced shutdown with its one-second inhibit.
// assumes the serial port decodes the clear-alert command into a one-cycle
// pulse and returns the two status bytes from the outputs below.
`timescale 1ns/1ns
`include "pfs_params.svh"

module pfs_supervisor #(
  parameter int HOLD_CYC =
    (`PFS_T_HOLD_NS * `PFS_CLK_MHZ + 999) / 1000,
  parameter int TMO_CYC  = `PFS_T_PGTMO_US * `PFS_CLK_MHZ,
  parameter int INH_CYC  = `PFS_T_INHIBIT_MS * 1000 * `PFS_CLK_MHZ
) (
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  input  wire logic                              clk_en,
  input  wire logic [`PFS_NUM_RAILS-1:0]         rail_window_raw,
  input  wire logic [`PFS_NUM_RAILS-1:0]         rail_enabled,
  input  wire logic [`PFS_NUM_RAILS-1:0]         slew_active,
  input  wire logic [`PFS_NUM_RAILS-1:0]         slew_pg_ignore,
  input  wire pfs_pkg::pfs_mon_s                 monitor_raw,
  input  wire logic                              pg_timeout_no_reset,
  input  wire logic                              clear_alert_command,
  output logic                                   power_good_out,
  output logic [7:0]                             power_good_status,
  output logic [7:0]                             fault_event_status,
  output logic                                   alert_n,
  output logic                                   wake,
  output logic                                   enables_ignored,
  output logic                                   regulators_off,
  output logic                                   output_enable_register_clear,
  output logic                                   hard_reset,
  output pfs_pkg::pfs_seq_e                      seq_state,
  output logic                                   supply_lockout
);
  import pfs_pkg::*;

  localparam int FILT_CYC = (`PFS_T_FILT_NS * `PFS_CLK_MHZ + 999) / 1000;

  pfs_top_s                    st_q;
  pfs_top_s                    st_d;
  pfs_mon_s                    mon;
  logic [`PFS_NUM_RAILS-1:0]   rail_window;
  logic [`PFS_NUM_RAILS-1:0]   rail_good;
  logic [`PFS_NUM_SYNC-1:0]    sync_q;
  logic                        any_en;
  logic                        all_good;
  logic                        slew_block;
  logic [7:`PFS_FES_LO]        cond;
  logic [7:`PFS_FES_LO]        rise;
  logic [7:`PFS_FES_LO]        is_fault;
  logic                        shut_req;
  logic                        fault_live;

  // every asynchronous pin shares one synchroniser bank
  // lockout holds until the pin has really been seen
  pfs_sync #(
    .W       (`PFS_NUM_SYNC),
    .RST_VAL (`PFS_SYNC_RESET)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .d        ({monitor_raw, rail_window_raw}),
    .q        (sync_q)
  );

  assign rail_window = sync_q[`PFS_NUM_RAILS-1:0];
  assign mon         = pfs_mon_s'(sync_q[`PFS_NUM_SYNC-1:`PFS_NUM_RAILS]);

  // per-rail qualification, bit index equals rail position
  for (genvar r = 0; r < `PFS_NUM_RAILS; r++) begin : g_rail
    pfs_rail_filter #(
      .FILT_CYC (FILT_CYC),
      .HOLD_CYC (HOLD_CYC)
    ) u_filt (
      .core_clk  (core_clk),
      .reset     (reset),
      .clk_en    (clk_en),
      .rail_on   (rail_enabled[r]),
      .in_window (rail_window[r]),
      .good      (rail_good[r])
    );
  end

  assign any_en = |rail_enabled;

  assign all_good = &(rail_good | ~rail_enabled);

  assign slew_block = |(slew_active & rail_enabled & ~slew_pg_ignore);

  // fault bits in the status field; warnings are the rest
  assign is_fault = 5'b10101;

  always_comb begin
    cond[`PFS_FES_UV_WARN]  = mon.uv_warn & any_en;
    cond[`PFS_FES_OT_WARN]  = mon.ot_warn & any_en;
    cond[`PFS_FES_OT_FAULT] = mon.ot_fault & any_en;
    cond[`PFS_FES_UV_FAULT] = mon.uv_fault & any_en & st_q.uv_armed;
    cond[`PFS_FES_PG_TMO]   = st_q.tmo;
  end

  assign rise = cond & ~st_q.cond_prev;

  assign shut_req = cond[`PFS_FES_OT_FAULT] | cond[`PFS_FES_UV_FAULT] |
                    (st_q.tmo & ~pg_timeout_no_reset);

  // synchronised pins: the monitors are gated while the rails are off, so the
  // re-enable check looks at the live lines instead
  assign fault_live = mon.uv_fault | mon.ot_fault | st_q.tmo;

  always_comb begin
    st_d            = st_q;
    st_d.hard_reset = 1'b0;
    st_d.output_enable_register_clear = 1'b0;
    st_d.cond_prev  = cond;

    if (!mon.uv_fault) begin
      st_d.uv_armed = 1'b1;
    end

    // low-time counter
    // rails are forced off outside run, so no low time counts there
    if (st_q.pg || !any_en || (st_q.seq != PFS_SEQ_RUN)) begin
      st_d.tmo_cnt = '0;
      st_d.tmo     = 1'b0;
    end else if (st_q.tmo_cnt == `PFS_TMO_CW'(TMO_CYC - 1)) begin
      st_d.tmo = 1'b1;
    end else begin
      st_d.tmo_cnt = st_q.tmo_cnt + `PFS_TMO_CW'(1);
    end

    for (int b = `PFS_FES_LO; b <= 7; b++) begin
      if (cond[b]) begin
        // set wins over a clear in the same cycle
        st_d.status[b] = 1'b1;
        if (clear_alert_command && st_q.status[b]) begin
          st_d.clr_seen[b] = 1'b1;
        end
      end else if (st_q.status[b]) begin
        if (clear_alert_command || st_q.clr_seen[b]) begin
          st_d.clr_seen[b] = 1'b1;
          if (!is_fault[b] || st_q.seq != PFS_SEQ_DOWN) begin
            st_d.status[b]   = 1'b0;
            st_d.clr_seen[b] = 1'b0;
          end
        end
      end
    end

    // fault alert latch, cleared only by the command
    if (|(rise & is_fault)) begin
      st_d.fault_alert = 1'b1;
    end else if (clear_alert_command) begin
      st_d.fault_alert = 1'b0;
    end

    unique case (st_q.seq)
      PFS_SEQ_RUN: begin
        if (shut_req) begin
          st_d.seq        = PFS_SEQ_DOWN;
          st_d.inh_cnt    = '0;
          st_d.hard_reset = 1'b1;
          st_d.output_enable_register_clear = 1'b1;
        end
      end
      PFS_SEQ_DOWN: begin
        if (st_q.inh_cnt == `PFS_INH_CW'(INH_CYC - 1)) begin
          st_d.seq = PFS_SEQ_OFF;
        end else begin
          st_d.inh_cnt = st_q.inh_cnt + `PFS_INH_CW'(1);
        end
      end
      PFS_SEQ_OFF: begin
        // wait for fault gone and request
        if (!fault_live && mon.power_on_request) begin
          st_d.seq = PFS_SEQ_RUN;
        end
      end
      default: begin
        st_d.seq = PFS_SEQ_OFF;
      end
    endcase

    st_d.wake = (st_d.seq == PFS_SEQ_RUN) & mon.power_on_request;

    st_d.pg = any_en & all_good & ~slew_block &
              (st_d.seq == PFS_SEQ_RUN);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q     <= '0;
      st_q.seq <= PFS_SEQ_RUN;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign power_good_out = st_q.pg;

  assign power_good_status = rail_good;

  // status bits are never cleared by the shutdown
  assign fault_event_status = {st_q.status, 3'h0};

  // alert from warnings and fault latch
  assign alert_n = ~(st_q.fault_alert |
                     st_q.status[`PFS_FES_UV_WARN] |
                     st_q.status[`PFS_FES_OT_WARN]);

  assign wake            = st_q.wake;
  assign seq_state       = st_q.seq;
  assign hard_reset      = st_q.hard_reset;
  assign output_enable_register_clear      = st_q.output_enable_register_clear;

  // enables ignored through down and off
  assign enables_ignored = (st_q.seq != PFS_SEQ_RUN);

  assign supply_lockout  = ~st_q.uv_armed;
  assign regulators_off  = (st_q.seq != PFS_SEQ_RUN) | ~st_q.uv_armed;
endmodule

/* File: dv/pfs_supervisor_sva.sv */
// port checker for the power fault supervisor
// bound into pfs_supervisor; one clock domain
`timescale 1ns/1ns

module pfs_supervisor_sva #(
  parameter int INH_CYC = 1
) (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [7:0] rail_enabled,
  input wire logic [7:0] slew_active,
  input wire logic [7:0] slew_pg_ignore,
  input wire logic       power_good_out,
  input wire logic [7:0] power_good_status,
  input wire logic [7:0] fault_event_status,
  input wire logic       alert_n,
  input wire logic       wake,
  input wire logic       enables_ignored,
  input wire logic       regulators_off,
  input wire logic       output_enable_register_clear,
  input wire logic       hard_reset,
  input wire pfs_pkg::pfs_seq_e seq_state
);
  import pfs_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [31:0] dn_q;
  logic        dn;
  assign dn = seq_state == PFS_SEQ_DOWN;
  // cycles spent powered down, to time the inhibit
  always_ff @(posedge core_clk or posedge reset)
    if (reset) dn_q <= 32'h0;
    else dn_q <= dn ? dn_q + 32'h1 : 32'h0;

  property p_lo; fault_event_status[2:0] == 3'h0; endproperty
  a_lo: assert property (p_lo)
    else $error("low status bits set");
  property p_off; (rail_enabled == 8'h00) [*2] |->
    !power_good_out && power_good_status == 8'h00; endproperty
  a_off: assert property (p_off)
    else $error("power good with no rail on");
  property p_wrn; fault_event_status[4] || fault_event_status[6]
    |-> !alert_n; endproperty
  a_wrn: assert property (p_wrn)
    else $error("warning without alert");
  property p_flt; $rose(fault_event_status[7]) |-> !alert_n; endproperty
  a_flt: assert property (p_flt)
    else $error("fault without alert");
  property p_sd; hard_reset |-> output_enable_register_clear && dn && !wake
    && enables_ignored; endproperty
  a_sd: assert property (p_sd)
    else $error("shutdown actions missing");
  property p_dn; dn |-> regulators_off && !power_good_out
    && !wake; endproperty
  a_dn: assert property (p_dn)
    else $error("rails live while down");
  property p_end; dn && dn_q == 32'(INH_CYC - 1)
    |=> seq_state == PFS_SEQ_OFF; endproperty
  a_end: assert property (p_end)
    else $error("inhibit end missed");
  property p_hold; dn && dn_q < 32'(INH_CYC - 1) |=> dn; endproperty
  a_hold: assert property (p_hold)
    else $error("inhibit cut short");
  property p_slw; |(slew_active & ~slew_pg_ignore)
    |=> !power_good_out; endproperty
  a_slw: assert property (p_slw)
    else $error("power good during slew");
  property p_kp; dn && fault_event_status[7]
    |=> fault_event_status[7]; endproperty
  a_kp: assert property (p_kp)
    else $error("fault bit lost while down");
endmodule

bind pfs_supervisor pfs_supervisor_sva #(.INH_CYC(INH_CYC)) u_sva (
  .core_clk, .reset, .rail_enabled, .slew_active, .slew_pg_ignore,
  .power_good_out, .power_good_status, .fault_event_status, .alert_n,
  .wake, .enables_ignored, .regulators_off, .output_enable_register_clear, .hard_reset,
  .seq_state
);

/* File: dv/pfs_host_model.sv */
// host stand-in: turns a request level into one clear pulse
// assumes requests change at the falling edge
`timescale 1ns/1ns

module pfs_host_model (
  input  wire logic core_clk,
  input  wire logic send_clear,
  output logic      clear_alert_command
);
  logic req_q   = 1'b0;
  logic prev_q  = 1'b0;
  logic pulse_q = 1'b0;
  // sampled on the rising edge so the bench never races the model
  always @(posedge core_clk) req_q <= send_clear;
  always @(negedge core_clk) begin
    pulse_q <= req_q && !prev_q;
    prev_q  <= req_q;
  end
  assign clear_alert_command = pulse_q;
endmodule

/* File: dv/pfs_supervisor_test.sv */
// self-checking bench for pfs_supervisor with short hold, timeout and inhibit timers; the filter keeps its full length
// assumes the host model for the clear pulse; clk_en held high
`timescale 1ns/1ns

module pfs_supervisor_test;
  import pfs_pkg::*;
  localparam int HOLD = 20;
  localparam int INH  = 200;
  logic       core_clk;
  logic       reset;
  logic [7:0] win;
  logic [7:0] ena;
  logic [7:0] slw;
  logic [7:0] ign;
  pfs_mon_s   mon;
  logic       no_rst;
  logic       send_clear;
  logic       clr;
  logic       pg;
  logic [7:0] pgs;
  logic [7:0] fes;
  logic       alert_n;
  logic       wake;
  logic       ens_ign;
  logic       roff;
  logic       hard_reset;
  logic       ovc;
  pfs_seq_e   seq;
  logic       lockout;
  logic [7:0] exp;
  int         n_errors;
  int         samples_checked;
  int         i;

  pfs_supervisor #(.HOLD_CYC(HOLD), .TMO_CYC(100), .INH_CYC(INH)) uut (
    .core_clk(core_clk), .reset(reset), .clk_en(1'b1),
    .rail_window_raw(win), .rail_enabled(ena), .slew_active(slw),
    .slew_pg_ignore(ign), .monitor_raw(mon),
    .pg_timeout_no_reset(no_rst), .clear_alert_command(clr),
    .power_good_out(pg), .power_good_status(pgs),
    .fault_event_status(fes), .alert_n(alert_n), .wake(wake),
    .enables_ignored(ens_ign), .regulators_off(roff), .output_enable_register_clear(ovc),
    .hard_reset(hard_reset), .seq_state(seq), .supply_lockout(lockout)
  );
  pfs_host_model host (
    .core_clk(core_clk), .send_clear(send_clear),
    .clear_alert_command(clr)
  );

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {7'h0, e}, {7'h0, g});
  endtask
  task automatic clear_alert;
    send_clear = 1'b1;
    cyc(2);
    send_clear = 1'b0;
    cyc(1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 20);
    n_errors++;
    tally_and_finish;
  end

  initial begin
    n_errors = 0;
    samples_checked = 0;
    reset = 1'b1;
    win = 8'hff;
    ena = 8'h00;
    slw = 8'h00;
    ign = 8'h00;
    mon = pfs_mon_s'(5'h10);
    no_rst = 1'b1;
    send_clear = 1'b0;
    cyc(4);
    chk1("lockout", 1'b1, lockout);
    reset = 1'b0;
    mon.ot_warn = 1'b1;
    cyc(2);
    chk1("lockout", 1'b1, lockout);
    cyc(6);
    chk1("lockout", 1'b0, lockout);
    chk("pgs", 8'h00, pgs);
    chk1("pg", 1'b0, pg);
    chk("fes", 8'h00, fes);
    mon.ot_warn = 1'b0;
    cyc(5);
    ena = 8'hff;
    cyc(HOLD - 3);
    chk1("pg", 1'b0, pg);
    cyc(12);
    chk("pgs", 8'hff, pgs);
    chk1("pg", 1'b1, pg);
    win = 8'hf7;
    cyc(1240);
    chk("pgs", 8'hff, pgs);
    cyc(25);
    chk("pgs", 8'hf7, pgs);
    chk1("pg", 1'b0, pg);
    win = 8'hff;
    cyc(HOLD - 3);
    chk("pgs", 8'hf7, pgs);
    cyc(12);
    chk("pgs", 8'hff, pgs);
    slw = 8'h01;
    cyc(3);
    chk1("pg", 1'b0, pg);
    chk("pgs", 8'hff, pgs);
    ign = 8'h01;
    cyc(3);
    chk1("pg", 1'b1, pg);
    slw = 8'h00;
    for (i = 0; i < 2; i++) begin
      exp = (i == 0) ? 8'h10 : 8'h40;
      mon.uv_warn = (i == 0);
      mon.ot_warn = (i == 1);
      cyc(6);
      chk("fes", exp, fes);
      chk1("alert_n", 1'b0, alert_n);
      clear_alert;
      cyc(4);
      chk("fes", exp, fes);
      mon.uv_warn = 1'b0;
      mon.ot_warn = 1'b0;
      cyc(6);
      chk("fes", 8'h00, fes);
      chk1("alert_n", 1'b1, alert_n);
    end
    win = 8'hf7;
    cyc(1400);
    chk("fes", 8'h08, fes);
    chk1("alert_n", 1'b0, alert_n);
    chk("seq", 8'h00, {6'h0, seq});
    win = 8'hff;
    clear_alert;
    cyc(HOLD + 12);
    chk("fes", 8'h00, fes);
    chk1("alert_n", 1'b1, alert_n);
    mon.ot_fault = 1'b1;
    i = 0;
    while (hard_reset !== 1'b1 && i < 20) begin
      cyc(1);
      i++;
    end
    chk1("hard_reset", 1'b1, hard_reset);
    chk1("ovc", 1'b1, ovc);
    chk("fes", 8'h80, fes);
    chk1("alert_n", 1'b0, alert_n);
    chk1("ens_ign", 1'b1, ens_ign);
    chk1("roff", 1'b1, roff);
    cyc(INH / 4);
    chk("fes", 8'h80, fes);
    chk1("alert_n", 1'b0, alert_n);
    clear_alert;
    chk1("alert_n", 1'b1, alert_n);
    chk("fes", 8'h80, fes);
    mon.ot_fault = 1'b0;
    cyc(INH);
    chk("seq", 8'h00, {6'h0, seq});
    chk1("wake", 1'b1, wake);
    chk("fes", 8'h00, fes);
    no_rst = 1'b0;
    win = 8'hf7;
    cyc(1360);
    chk("seq", 8'h01, {6'h0, seq});
    chk("fes", 8'h08, fes);
    chk1("alert_n", 1'b0, alert_n);
    tally_and_finish;
  end
endmodule
